// File: rtl/vec_mask_consts.svh
`ifndef VEC_MASK_CONSTS_SVH
`define VEC_MASK_CONSTS_SVH
`define OFF_SPEC_VERSION   8'h08
`define OFF_IRQ_MASK_SET   8'h0c
`define OFF_IRQ_MASK_CLEAR 8'h10
`define OFF_EVT_STATUS     8'h20
`define OFF_EVT_MASK       8'h24
`define OFF_VEC_MODE       8'h28
`define MAJOR_NUMBER       16'h0001
`define MINOR_LEVEL1       8'h00
`define MINOR_LEVEL2       8'h01
`define MINOR_LEVEL3       8'h02
`define MASK_RESET         32'h0000_0000
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10
`define MODE_PIN           2'h0
`define MODE_MSI_SINGLE    2'h1
`define MODE_MSI_MULTI     2'h2
`define MODE_MSIX          2'h3
`endif

// File: rtl/vec_mask_pkg.sv
package vec_mask_pkg;
  typedef struct packed {
    logic [15:0] major_number;
    logic [7:0]  minor_number;
    logic [7:0]  reserved;
  } spec_version_t;
  typedef enum logic [1:0] {
    w_idle,
    w_resp
  } wr_state_t;
endpackage : vec_mask_pkg

// File: rtl/vec_mask_regs.sv
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "vec_mask_consts.svh"
module vec_mask_regs
  import vec_mask_pkg::*;
#(
  parameter logic [1:0] COMPLIANCE = 2'h2
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] vec_request,
  output logic [31:0]      msi_pending,
  output logic             pin_irq,
  output logic             msi_irq,
  output logic             irq
);
  spec_version_t ver;
  logic [31:0] vec_mask;
  logic [31:0] next_vec_mask;
  logic [31:0] vec_pend;
  logic [31:0] next_vec_pend;
  logic [31:0] evt_status;
  logic [31:0] next_evt_status;
  logic [31:0] evt_mask;
  logic [31:0] next_evt_mask;
  logic [1:0]  vec_mode;
  logic [1:0]  next_vec_mode;
  logic [31:0] msi_pending_r;
  logic [31:0] next_msi_pending;
  logic        pin_irq_r;
  logic        next_pin_irq;
  logic        msi_irq_r;
  logic        next_msi_irq;
  logic        irq_r;
  logic        next_irq;
  logic        aw_got;
  logic        next_aw_got;
  logic        w_got;
  logic        next_w_got;
  logic        awready_r;
  logic        wready_r;
  logic        arready_r;
  logic [7:0]  aw_addr;
  logic [7:0]  next_aw_addr;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0]  w_strb;
  logic [3:0]  next_w_strb;
  logic        bvalid;
  logic        next_bvalid;
  logic [1:0]  bresp;
  logic [1:0]  next_bresp;
  logic        rvalid;
  logic        next_rvalid;
  logic [1:0]  rresp;
  logic [1:0]  next_rresp;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        do_wr;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [31:0] sync1;
  logic [31:0] next_sync1;
  logic [31:0] sync2;
  logic [31:0] next_sync2;
  logic [31:0] req_prev;
  logic [31:0] next_req_prev;
  logic [31:0] req_rise;
  logic [31:0] vec_fire;
  logic [31:0] vec_hold;
  logic [31:0] vec_live;

  always_comb begin
    ver.major_number = `MAJOR_NUMBER;
    ver.reserved     = 8'h00;
    case (COMPLIANCE)
      2'h0:    ver.minor_number = `MINOR_LEVEL1;
      2'h1:    ver.minor_number = `MINOR_LEVEL2;
      default: ver.minor_number = `MINOR_LEVEL3;
    endcase
  end

  // vector requests come from outside the clock domain
  always_comb begin
    next_sync1    = vec_request;
    next_sync2    = sync1;
    next_req_prev = sync2;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1    <= 32'h0;
      sync2    <= 32'h0;
      req_prev <= 32'h0;
    end else begin
      sync1    <= next_sync1;
      sync2    <= next_sync2;
      req_prev <= next_req_prev;
    end
  end
  assign req_rise = sync2 & ~req_prev;

  // per vector: fires once pending and unmasked, held while masked
  for (genvar gi = 0; gi < 32; gi++) begin : g_vec
    assign vec_fire[gi] = vec_pend[gi] & ~vec_mask[gi];
    assign vec_hold[gi] = (vec_pend[gi] | req_rise[gi]) & ~vec_fire[gi];
    assign vec_live[gi] = sync2[gi] & ~vec_mask[gi];
  end

  always_comb begin
    next_aw_got  = aw_got;
    next_w_got   = w_got;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (s_axi_awvalid && awready_r) begin
      next_aw_got  = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      next_w_got  = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_wr = aw_got && w_got && !bvalid;
    if (do_wr) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      case (aw_addr)
        `OFF_SPEC_VERSION, `OFF_IRQ_MASK_SET, `OFF_IRQ_MASK_CLEAR,
        `OFF_EVT_STATUS, `OFF_EVT_MASK, `OFF_VEC_MODE: next_bresp = `RESP_OKAY;
        default: next_bresp = `RESP_SLVERR;
      endcase
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_comb begin
    wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wbits = w_data & wmask;
    next_vec_mask = vec_mask;
    next_evt_mask = evt_mask;
    next_vec_mode = vec_mode;
    next_evt_status = evt_status;
    if (do_wr) begin
      case (aw_addr)
        `OFF_IRQ_MASK_SET:   next_vec_mask = vec_mask | wbits;
        `OFF_IRQ_MASK_CLEAR: next_vec_mask = vec_mask & ~wbits;
        `OFF_EVT_STATUS:     next_evt_status = evt_status & ~wbits;
        `OFF_EVT_MASK:       next_evt_mask = (evt_mask & ~wmask) | wbits;
        `OFF_VEC_MODE:       if (w_strb[0]) next_vec_mode = w_data[1:0];
        default:             next_evt_status = evt_status;
      endcase
    end
    // set wins over a same-cycle clear
    next_evt_status = next_evt_status | req_rise;
    // a request stays pending while masked, then fires on unmask
    next_vec_pend = vec_hold;
    next_msi_pending = vec_fire;
    next_pin_irq = (vec_mode == `MODE_PIN) && |vec_live;
    next_msi_irq = (vec_mode == `MODE_MSI_SINGLE || vec_mode == `MODE_MSI_MULTI)
                   && |vec_fire;
    next_irq = |(evt_status & ~evt_mask);
  end

  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = `RESP_OKAY;
      case (s_axi_araddr)
        `OFF_SPEC_VERSION:   next_rdata = ver;
        // under msi-x the host stays away; reads still answer
        `OFF_IRQ_MASK_SET:   next_rdata = vec_mask;
        `OFF_IRQ_MASK_CLEAR: next_rdata = vec_mask;
        `OFF_EVT_STATUS:     next_rdata = evt_status;
        `OFF_EVT_MASK:       next_rdata = evt_mask;
        `OFF_VEC_MODE:       next_rdata = {30'h0, vec_mode};
        default: begin
          next_rdata = 32'h0;
          next_rresp = `RESP_SLVERR;
        end
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // ready stays low from acceptance until the response has been taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got    <= 1'b0;
      w_got     <= 1'b0;
      aw_addr   <= 8'h0;
      w_data    <= 32'h0;
      w_strb    <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OKAY;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
    end else begin
      aw_got    <= next_aw_got;
      w_got     <= next_w_got;
      aw_addr   <= next_aw_addr;
      w_data    <= next_w_data;
      w_strb    <= next_w_strb;
      bvalid    <= next_bvalid;
      bresp     <= next_bresp;
      awready_r <= !next_aw_got && !next_bvalid;
      wready_r  <= !next_w_got && !next_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid    <= 1'b0;
      rresp     <= `RESP_OKAY;
      rdata     <= 32'h0;
      arready_r <= 1'b1;
    end else begin
      rvalid    <= next_rvalid;
      rresp     <= next_rresp;
      rdata     <= next_rdata;
      arready_r <= !next_rvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_mask      <= `MASK_RESET;
      vec_pend      <= 32'h0;
      evt_status    <= 32'h0;
      evt_mask      <= 32'hffff_ffff;
      vec_mode      <= `MODE_PIN;
      msi_pending_r <= 32'h0;
      pin_irq_r     <= 1'b0;
      msi_irq_r     <= 1'b0;
      irq_r         <= 1'b0;
    end else begin
      vec_mask      <= next_vec_mask;
      vec_pend      <= next_vec_pend;
      evt_status    <= next_evt_status;
      evt_mask      <= next_evt_mask;
      vec_mode      <= next_vec_mode;
      msi_pending_r <= next_msi_pending;
      pin_irq_r     <= next_pin_irq;
      msi_irq_r     <= next_msi_irq;
      irq_r         <= next_irq;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;
  assign msi_pending   = msi_pending_r;
  assign pin_irq       = pin_irq_r;
  assign msi_irq       = msi_irq_r;
  assign irq           = irq_r;
endmodule : vec_mask_regs

// File: testbench/vec_mask_assertions.sv
`timescale 1ns/10ps
module vec_mask_assertions (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [31:0] msi_pending,
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  AST_RD_ANSWER: assert property (rd_take |=> s_axi_rvalid) else $error("read unanswered");
  AST_WR_ANSWER: assert property (wr_take |=> ##1 s_axi_bvalid) else $error("write unanswered");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken early");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw early");
  AST_RESET_QUIET: assert property ($rose(aresetn) |-> msi_pending == 32'h0 && !irq)
    else $error("outputs not clear after reset");
endmodule : vec_mask_assertions

// File: testbench/event_source.sv
`timescale 1ns/10ps
module event_source (
  input  wire logic        aclk,
  output logic      [31:0] vec_request
);
  initial vec_request = 32'h0;
  // sets one request level, then holds it past the two-stage synchroniser
  task automatic drive(input int v, input logic lvl);
    vec_request[v] <= lvl;
    repeat (5) @(posedge aclk);
  endtask : drive
endmodule : event_source

// File: testbench/testbench.sv
`timescale 1ns/10ps
`include "vec_mask_consts.svh"
module testbench;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        pin_irq, msi_irq, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, vec_request, msi_pending, data, wdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  int          n_mismatch = 0, check_count = 0, cycles = 0, seed = 42, model_mask = 0;
  int          msi_seen = 0, pend_seen = 0, msi_base = 0, pend_base = 0;
  always #10 aclk = ~aclk;
  vec_mask_regs u_vec_mask_regs (.*);
  event_source u_src (.aclk(aclk), .vec_request(vec_request));
  always @(posedge aclk) begin
    cycles++;
    if (msi_irq === 1'b1) msi_seen++;
    if (msi_pending[1] === 1'b1) pend_seen++;
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    {data, resp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic wrap_up;
    if (n_mismatch == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hf};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFF_SPEC_VERSION);
    check("version", {`MAJOR_NUMBER, `MINOR_LEVEL3, 8'h00}, data);
    rd(`OFF_IRQ_MASK_SET);
    check("mask at reset", 32'h0, data);
    for (int i = 0; i < 12; i++) begin
      wdat = $random(seed);
      wr(i % 2 ? `OFF_IRQ_MASK_CLEAR : `OFF_IRQ_MASK_SET, wdat);
      model_mask = i % 2 ? model_mask & ~wdat : model_mask | wdat;
      rd(i % 3 ? `OFF_IRQ_MASK_SET : `OFF_IRQ_MASK_CLEAR);
      check("live mask", model_mask, data);
    end
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    model_mask = 0;
    rd(`OFF_IRQ_MASK_CLEAR);
    check("mask after reset", 32'h0, data);
    rd(8'h04);
    check("unmapped resp", {30'h0, `RESP_SLVERR}, {30'h0, resp});
    check("unmapped data", 32'h0, data);
    wr(`OFF_EVT_MASK, 32'hffff_fffe);
    u_src.drive(0, 1'b1);
    check("irq raised", 32'h1, {31'h0, irq});
    wr(`OFF_EVT_MASK, 32'hffff_ffff);
    u_src.drive(0, 1'b0);
    check("irq masked", 32'h0, {31'h0, irq});
    wr(`OFF_EVT_MASK, 32'hffff_fffe);
    wr(`OFF_EVT_STATUS, 32'h1);
    u_src.drive(0, 1'b0);
    check("irq cleared", 32'h0, {31'h0, irq});
    for (int m = 0; m < 3; m++) begin
      wr(`OFF_VEC_MODE, m);
      wr(`OFF_IRQ_MASK_SET, 32'h2);
      u_src.drive(1, 1'b1);
      check("masked vector", 32'h0, {29'h0, pin_irq, msi_irq, msi_pending[1]});
      {msi_base, pend_base} = {msi_seen, pend_seen};
      wr(`OFF_IRQ_MASK_CLEAR, 32'h2);
      u_src.drive(1, 1'b1);
      check("pin after unmask", {31'h0, m == 0}, {31'h0, pin_irq});
      check("msi after unmask", {31'h0, m != 0}, {31'h0, msi_seen != msi_base});
      check("pending after unmask", 32'h1, {31'h0, pend_seen != pend_base});
      u_src.drive(1, 1'b0);
    end
    wr(`OFF_VEC_MODE, 32'h3);
    {msi_base, pend_base} = {msi_seen, pend_seen};
    u_src.drive(1, 1'b1);
    check("msix pin", 32'h0, {31'h0, pin_irq});
    check("msix msi", 32'h0, {31'h0, msi_seen != msi_base});
    u_src.drive(1, 1'b0);
    wrap_up();
  end
endmodule : testbench
bind vec_mask_regs vec_mask_assertions u_chk (.*);
